// ---- logic/drw_defs.svh ----
// drw_defs.svh: constants for the refresh/wait sequencer and its host end
// assumes: included by bare name from logic files, 50 MHz system clock
`ifndef DRW_DEFS_SVH
`define DRW_DEFS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DRW_CLK_NS          20
`define DRW_CS_SETUP_NS     30
`define DRW_ADDR_SETUP_NS   10
`define DRW_CS_SETUP_CYC    ((`DRW_CS_SETUP_NS + `DRW_CLK_NS - 1) / `DRW_CLK_NS)
`define DRW_PRECHARGE_CYC   2
`define DRW_EXTRA_WAIT_CYC  1
`define DRW_REFRESH_CYC     4

// ----------------------------------------------------------------------
// controller mode codes
// ----------------------------------------------------------------------
`define DRW_MODE_AUTO_RFSH  3'h1
`define DRW_MODE_NORMAL     3'h5

// ----------------------------------------------------------------------
// host apb map
// ----------------------------------------------------------------------
`define DRW_REG_CMD         12'h000
`define DRW_REG_CFG         12'h004
`define DRW_REG_STAT        12'h008
`define DRW_CMD_GO_BIT      0
`define DRW_CMD_WR_BIT      1
`define DRW_CMD_CS_BIT      2
`define DRW_CFG_REFRESH_PERIOD_CLOCK_BIT    0
`define DRW_CFG_LATE_BIT    1
`define DRW_CFG_WRD_BIT     2
`define DRW_CFG_WWR_BIT     3
`define DRW_CFG_RESET       32'h0000_0000

`endif

// ---- logic/drw_pkg.sv ----
// drw_pkg.sv: shared types for the sequencer and its bus end
// assumes: nothing beyond the defs header
package drw_pkg;
    typedef enum logic [5:0] {
        DRW_IDLE  = 6'h01,
        DRW_T1    = 6'h02,
        DRW_T2    = 6'h04,
        DRW_T3    = 6'h08,
        DRW_TW    = 6'h10,
        DRW_T4    = 6'h20
    } drw_bus_state_t;

    typedef enum logic [3:0] {
        DRW_RF_IDLE = 4'h1,
        DRW_RF_RUN  = 4'h2,
        DRW_RF_PRE  = 4'h4,
        DRW_RF_HID  = 4'h8
    } drw_rf_state_t;
endpackage

// ---- logic/drw_link_if.sv ----
// drw_link_if.sv: local bus between processor end and sequencer
// assumes: one system clock shared by both ends
`timescale 1ns/100ps
interface drw_link_if;
    logic mem_select_n;            // memory chip select, low active
    logic addr_latch;              // address latch strobe
    logic cpu_write_status_bit;    // high for write cycles
    logic cpu_ready_out_n;         // low asks for a wait state
    logic [2:0] ctrl_mode;         // mode input of the dram controller
    logic row_strobe_request_n;    // row strobe request, low active

    modport seq (
        input  mem_select_n,
        input  addr_latch,
        input  cpu_write_status_bit,
        output cpu_ready_out_n,
        output ctrl_mode,
        output row_strobe_request_n
    );
    modport cpu (
        output mem_select_n,
        output addr_latch,
        output cpu_write_status_bit,
        input  cpu_ready_out_n,
        input  ctrl_mode,
        input  row_strobe_request_n
    );
endinterface

// ---- logic/drw_delay_cnt.sv ----
// drw_delay_cnt.sv: load-and-count-down timer
// assumes: system clock, async low reset
`timescale 1ns/100ps
module drw_delay_cnt #(
    parameter int W = 4
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    if (W < 2) begin : g_bad_w
        $error("drw_delay_cnt: W too small");
    end

    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = value_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = (cnt_q == '0);
endmodule

// ---- logic/drw_seq.sv ----
// drw_seq.sv: refresh arbiter, row strobe and wait-state sequencer
// assumes: bus inputs synchronous to clk_sys_i, async low reset
//
// How it works
// - cycle starts on latch strobe; select marks dram
// - hidden refresh on foreign access, clock high
// - no hidden refresh means request at fall
// - idle dram plus request forces mode 1
// - dram access waits through refresh, precharge
// - held access then proceeds, not dropped
// - forced refresh runs during foreign accesses
// - extra state adds exactly one clock
// - read and write extra states independent
// - no extra state in hidden refresh cycles
// - direction status splits reads, writes; reads earlier
// - read strobe in T2 or T3 by select
// - system delays strobe when late select high
// - tied select: no hidden refresh, address setup
// - external logic makes byte write strobes
// - other latch strobes fixed outside first
// - strobe high two clocks between accesses
// - mode output 5, 1 only during forced
// - low ready output requests wait states
`timescale 1ns/100ps
`include "drw_defs.svh"
module drw_seq
    import drw_pkg::*;
#(
    parameter int REFRESH_CYC = `DRW_REFRESH_CYC
) (
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    input  wire logic  refresh_period_clock_i,
    input  wire logic  late_read_strobe_select_i,
    input  wire logic  read_extra_state_select_i,
    input  wire logic  write_extra_state_select_i,
    output logic       refresh_pending_o,
    output logic       hidden_refresh_o,
    drw_link_if.seq    bus
);
    drw_bus_state_t bst_q, bst_d;
    drw_rf_state_t  rst_q, rst_d;
    logic is_dram_q, is_dram_d;
    logic is_write_q, is_write_d;
    logic hold;
    logic pending_q, pending_d;
    logic hid_done_q, hid_done_d;
    logic refresh_period_clock_q;
    logic ras_q, ras_d;
    logic rdy_n_q, rdy_n_d;
    logic [2:0] mode_q, mode_d;
    logic tmr_load;
    logic [3:0] tmr_val;
    logic tmr_done;
    logic start;
    logic want_extra;
    logic rf_busy;

    if (REFRESH_CYC < 1 || REFRESH_CYC > 15) begin : g_bad_cyc
        $error("bad REFRESH_CYC");
    end

    drw_delay_cnt #(.W(4)) u_tmr (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .load_i    (tmr_load),
        .value_i   (tmr_val),
        .done_o    (tmr_done)
    );

    // ------------------------------------------------------------------
    // processor cycle tracking
    // ------------------------------------------------------------------
    assign start = bus.addr_latch;
    // refresh or precharge in force during the next cycle
    assign rf_busy = (rst_d == DRW_RF_RUN) || (rst_d == DRW_RF_PRE);
    assign want_extra = is_write_q ? write_extra_state_select_i
                                   : read_extra_state_select_i;

    always_comb begin
        bst_d      = bst_q;
        is_dram_d  = is_dram_q;
        is_write_d = is_write_q;
        ras_d      = 1'b0;
        rdy_n_d    = 1'b1;
        hold       = 1'b0;
        unique case (bst_q)
            DRW_IDLE: begin
                // latch cycle is T1; state follows the processor from T2
                if (start) begin
                    bst_d      = DRW_T2;
                    is_dram_d  = !bus.mem_select_n;
                    is_write_d = bus.cpu_write_status_bit;
                end
            end
            DRW_T1: bst_d = DRW_T2;
            DRW_T2: bst_d = DRW_T3;
            DRW_T3, DRW_TW: begin
                // mirror the processor: stay while ready is low
                if (!rdy_n_q) begin
                    bst_d = DRW_TW;
                end else begin
                    bst_d = DRW_T4;
                end
            end
            DRW_T4: bst_d = DRW_IDLE;
        endcase
        // row strobe: reads from T2 or T3 by late select, writes from TW or T4
        if (is_dram_q && !rf_busy) begin
            unique case (bst_d)
                DRW_T3: ras_d = !is_write_q;
                DRW_TW, DRW_T4: ras_d = 1'b1;
                default: ras_d = 1'b0;
            endcase
        end
        if (bst_q == DRW_IDLE && start && !bus.mem_select_n &&
            !bus.cpu_write_status_bit && !late_read_strobe_select_i &&
            !rf_busy) begin
            ras_d = 1'b1;
        end
        // hidden refresh strobe on a foreign access
        if (rst_d == DRW_RF_HID) begin
            ras_d = 1'b1;
        end
        // ready low while the processor must stay in T3 or TW
        if (bst_d == DRW_T3) begin
            hold = want_extra || rf_busy;
        end else if (bst_d == DRW_TW) begin
            hold = rf_busy || !ras_d;
        end
        rdy_n_d = !(is_dram_q && hold);
    end

    // ------------------------------------------------------------------
    // refresh arbitration
    // ------------------------------------------------------------------
    always_comb begin
        rst_d      = rst_q;
        pending_d  = pending_q;
        hid_done_d = hid_done_q;
        mode_d     = `DRW_MODE_NORMAL;
        tmr_load   = 1'b0;
        tmr_val    = 4'(REFRESH_CYC - 1);
        if (refresh_period_clock_i && !refresh_period_clock_q) begin
            hid_done_d = 1'b0;
        end
        unique case (rst_q)
            DRW_RF_IDLE: begin
                if (refresh_period_clock_i && start && bus.mem_select_n
                    && !hid_done_q) begin
                    rst_d = DRW_RF_HID;
                end else if (pending_q && (bst_q == DRW_IDLE ||
                             !is_dram_q) && !(start &&
                             !bus.mem_select_n)) begin
                    rst_d    = DRW_RF_RUN;
                    tmr_load = 1'b1;
                end
            end
            DRW_RF_HID: begin
                if (bst_q == DRW_T3) begin
                    rst_d      = DRW_RF_IDLE;
                    hid_done_d = 1'b1;
                    pending_d  = 1'b0;
                end
            end
            DRW_RF_RUN: begin
                if (tmr_done) begin
                    rst_d     = DRW_RF_PRE;
                    tmr_load  = 1'b1;
                    tmr_val   = 4'(`DRW_PRECHARGE_CYC - 1);
                    pending_d = 1'b0;
                end
            end
            DRW_RF_PRE: begin
                if (tmr_done) rst_d = DRW_RF_IDLE;
            end
        endcase
        // new request wins over a clear in the same cycle
        if (refresh_period_clock_q && !refresh_period_clock_i && !hid_done_d) begin
            pending_d = 1'b1;
        end
        if (rst_d == DRW_RF_RUN) begin
            mode_d = `DRW_MODE_AUTO_RFSH;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bst_q      <= DRW_IDLE;
            rst_q      <= DRW_RF_IDLE;
            is_dram_q  <= 1'b0;
            is_write_q <= 1'b0;
            pending_q  <= 1'b0;
            hid_done_q <= 1'b0;
            refresh_period_clock_q     <= 1'b0;
            ras_q      <= 1'b0;
            rdy_n_q    <= 1'b1;
            mode_q     <= `DRW_MODE_NORMAL;
        end else begin
            bst_q      <= bst_d;
            rst_q      <= rst_d;
            is_dram_q  <= is_dram_d;
            is_write_q <= is_write_d;
            pending_q  <= pending_d;
            hid_done_q <= hid_done_d;
            refresh_period_clock_q     <= refresh_period_clock_i;
            ras_q      <= ras_d;
            rdy_n_q    <= rdy_n_d;
            mode_q     <= mode_d;
        end
    end

    assign bus.row_strobe_request_n = !ras_q;
    assign bus.cpu_ready_out_n      = rdy_n_q;
    assign bus.ctrl_mode            = mode_q;
    assign refresh_pending_o        = pending_q;
    assign hidden_refresh_o         = (rst_q == DRW_RF_HID);
endmodule

// ---- logic/drw_cpu.sv ----
// drw_cpu.sv: processor-side bus end driven from apb registers
// assumes: apb master on clk_sys_i; one bus cycle per go command
`timescale 1ns/100ps
`include "drw_defs.svh"
module drw_cpu
    import drw_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             refresh_period_clock_o,
    output logic             late_read_strobe_select_o,
    output logic             read_extra_state_select_o,
    output logic             write_extra_state_select_o,
    drw_link_if.cpu          bus
);
    drw_bus_state_t st_q, st_d;
    logic [31:0] cfg_q, cfg_d;
    logic        wr_q, wr_d;
    logic        cs_q, cs_d;
    logic [7:0]  waits_q, waits_d;
    logic        acc;
    logic        hit;

    // ------------------------------------------------------------------
    // apb slave, answers in the access cycle
    // ------------------------------------------------------------------
    assign acc = psel_i && penable_i;
    assign hit = (paddr_i == `DRW_REG_CMD) || (paddr_i == `DRW_REG_CFG)
              || (paddr_i == `DRW_REG_STAT);
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && !hit;

    always_comb begin
        prdata_o = 32'h0000_0000;
        if (paddr_i == `DRW_REG_CFG) prdata_o = cfg_q;
        if (paddr_i == `DRW_REG_STAT) begin
            prdata_o = {16'h0000, waits_q, 2'h0, !bus.cpu_ready_out_n,
                        bus.ctrl_mode, st_q == DRW_IDLE,
                        !bus.row_strobe_request_n};
        end
    end

    // ------------------------------------------------------------------
    // processor cycle T1..T4 with waits from ready
    // ------------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        cfg_d   = cfg_q;
        wr_d    = wr_q;
        cs_d    = cs_q;
        waits_d = waits_q;
        if (acc && pwrite_i && paddr_i == `DRW_REG_CFG) cfg_d = pwdata_i;
        unique case (st_q)
            DRW_IDLE: begin
                if (acc && pwrite_i && paddr_i == `DRW_REG_CMD &&
                    pwdata_i[`DRW_CMD_GO_BIT]) begin
                    st_d    = DRW_T1;
                    wr_d    = pwdata_i[`DRW_CMD_WR_BIT];
                    cs_d    = pwdata_i[`DRW_CMD_CS_BIT];
                    waits_d = 8'h00;
                end
            end
            DRW_T1: st_d = DRW_T2;
            DRW_T2: st_d = DRW_T3;
            DRW_T3, DRW_TW: begin
                if (!bus.cpu_ready_out_n) begin
                    st_d    = DRW_TW;
                    waits_d = waits_q + 8'h01;
                end else begin
                    st_d = DRW_T4;
                end
            end
            DRW_T4: st_d = DRW_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q    <= DRW_IDLE;
            cfg_q   <= `DRW_CFG_RESET;
            wr_q    <= 1'b0;
            cs_q    <= 1'b0;
            waits_q <= 8'h00;
        end else begin
            st_q    <= st_d;
            cfg_q   <= cfg_d;
            wr_q    <= wr_d;
            cs_q    <= cs_d;
            waits_q <= waits_d;
        end
    end

    assign bus.addr_latch           = (st_q == DRW_T1);
    assign bus.mem_select_n         = !(cs_q && st_q != DRW_IDLE);
    assign bus.cpu_write_status_bit = wr_q && st_q != DRW_IDLE;
    assign refresh_period_clock_o     = cfg_q[`DRW_CFG_REFRESH_PERIOD_CLOCK_BIT];
    assign late_read_strobe_select_o  = cfg_q[`DRW_CFG_LATE_BIT];
    assign read_extra_state_select_o  = cfg_q[`DRW_CFG_WRD_BIT];
    assign write_extra_state_select_o = cfg_q[`DRW_CFG_WWR_BIT];
endmodule

// ---- dv/drw_seq_chk.sv ----
// drw_seq_chk.sv: checks on the local bus between the two ends
// assumes: instantiated beside drw_link_if, one clock domain
`timescale 1ns/100ps
`include "drw_defs.svh"
module drw_seq_chk #(
    parameter int REFRESH_CYC = `DRW_REFRESH_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       mem_select_n,
    input  wire logic       addr_latch,
    input  wire logic       cpu_write_status_bit,
    input  wire logic       cpu_ready_out_n,
    input  wire logic [2:0] ctrl_mode,
    input  wire logic       row_strobe_request_n
);
    logic [7:0] rf_cnt_q;
    logic [7:0] rf_cnt_d;
    logic [3:0] norm_q;
    logic [3:0] norm_d;
    logic       auto_m;
    logic       calm;
    logic       dram_lat;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    assign auto_m   = (ctrl_mode == `DRW_MODE_AUTO_RFSH);
    assign calm     = (&norm_q) && !auto_m;
    assign dram_lat = addr_latch && !mem_select_n;

    // forced refresh length and recent normal-mode history
    always_comb begin
        rf_cnt_d = auto_m ? rf_cnt_q + 8'h01 : 8'h00;
        norm_d   = {norm_q[2:0], !auto_m};
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rf_cnt_q <= 8'h00;
            norm_q   <= 4'hF;
        end else begin
            rf_cnt_q <= rf_cnt_d;
            norm_q   <= norm_d;
        end
    end

    chk_cycle_start: assert property (dram_lat |-> ##[1:30]
        !row_strobe_request_n) else $error("dram cycle without strobe");
    chk_mode_legal: assert property (auto_m ||
        ctrl_mode == `DRW_MODE_NORMAL) else $error("illegal mode code");
    chk_refresh_len: assert property (!auto_m && rf_cnt_q != 8'h00
        |-> rf_cnt_q == 8'(REFRESH_CYC)) else $error("refresh length off");
    chk_precharge_gap: assert property (!auto_m && $past(auto_m)
        |-> row_strobe_request_n [*2]) else $error("no precharge");
    chk_wait_one: assert property ($fell(cpu_ready_out_n) && calm
        |=> cpu_ready_out_n) else $error("extra state not one clock");
    chk_ready_dram: assert property (!cpu_ready_out_n
        |-> !mem_select_n) else $error("wait state on foreign access");
    chk_write_late: assert property (dram_lat && cpu_write_status_bit
        |-> row_strobe_request_n ##1 row_strobe_request_n)
        else $error("write strobe too early");
    chk_read_early: assert property (dram_lat && !cpu_write_status_bit
        && calm |-> ##[1:2] (!row_strobe_request_n || auto_m))
        else $error("read strobe too late");
    chk_gap_two: assert property ($rose(row_strobe_request_n)
        |=> row_strobe_request_n) else $error("strobe gap below two");

    cov_forced: cover property ($rose(auto_m));
    cov_write: cover property (dram_lat && cpu_write_status_bit);
    cov_wait: cover property ($fell(cpu_ready_out_n));
endmodule

// ---- dv/dram_refresh_wait_arbiter_test.sv ----
// dram_refresh_wait_arbiter_test.sv: self-checking bench, both ends
// assumes: drw_cpu faces drw_seq over drw_link_if; apb driven here
`timescale 1ns/100ps
`include "drw_defs.svh"
module dram_refresh_wait_arbiter_test;
    logic        clk_sys_i;
    logic        rst_n_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        refresh_period_clock;
    logic        late;
    logic        rwait;
    logic        wwait;
    logic        pend;
    logic        hidden;
    logic [31:0] st;
    logic [32:0] exp_r[$];
    int          exp_w[$];
    int          exp_d[$];
    int          err_total;
    int          n_tests;
    int          w_cnt;
    int          d_cnt;
    int          dly;
    bit          seen_hid;
    event        cyc_done;

    drw_link_if link ();
    drw_cpu u_drw_cpu (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .refresh_period_clock_o(refresh_period_clock),
        .late_read_strobe_select_o(late),
        .read_extra_state_select_o(rwait),
        .write_extra_state_select_o(wwait), .bus(link)
    );
    drw_seq #(.REFRESH_CYC(12)) u_drw_seq (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .refresh_period_clock_i(refresh_period_clock), .late_read_strobe_select_i(late),
        .read_extra_state_select_i(rwait),
        .write_extra_state_select_i(wwait), .refresh_pending_o(pend),
        .hidden_refresh_o(hidden), .bus(link)
    );
    drw_seq_chk #(.REFRESH_CYC(12)) u_drw_seq_chk (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .mem_select_n(link.mem_select_n), .addr_latch(link.addr_latch),
        .cpu_write_status_bit(link.cpu_write_status_bit),
        .cpu_ready_out_n(link.cpu_ready_out_n),
        .ctrl_mode(link.ctrl_mode),
        .row_strobe_request_n(link.row_strobe_request_n)
    );

    task automatic chk(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            err_total++;
            stop_test();
        end
        st = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [32:0] e);
        exp_r.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask

    function automatic bit cond(input int k);
        case (k)
            0: return pend === 1'h1;
            1: return link.ctrl_mode === `DRW_MODE_AUTO_RFSH;
            2: return link.ctrl_mode === `DRW_MODE_NORMAL;
            3: return link.addr_latch === 1'h1;
            default: return st[1] === 1'h1;
        endcase
    endfunction

    task automatic wait_on(input int k);
        int n;
        n = 0;
        while (!cond(k)) begin
            if (k == 4) apb(1'h0, `DRW_REG_STAT, 32'h0);
            else @(posedge clk_sys_i);
            n++;
            if (n > 300) begin
                err_total++;
                stop_test();
            end
        end
    endtask

    task automatic run_cyc(input logic dram, input logic wr,
                           input int ew, input int ed);
        exp_w.push_back(ew);
        exp_d.push_back(ed);
        apb(1'h1, `DRW_REG_CMD, {29'h0, dram, wr, 1'h1});
        wait_on(3);
        st = 32'h0;
        wait_on(4);
        repeat (4) @(posedge clk_sys_i);
        -> cyc_done;
    endtask

    // ------------------------------------------------------------------
    // monitor: measures bus cycles and apb read answers
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (link.addr_latch === 1'h1) begin
            w_cnt = 0;
            d_cnt = 0;
            dly   = 0;
        end else begin
            d_cnt++;
            if (link.cpu_ready_out_n === 1'h0) w_cnt++;
            if (link.row_strobe_request_n === 1'h0 && dly == 0) dly = d_cnt;
        end
        if (hidden === 1'h1) seen_hid = 1'h1;
        if (psel && penable && pready === 1'h1 && !pwrite
            && paddr != `DRW_REG_STAT) begin
            if (exp_r[0][32]) chk("pslverr", 33'h1, pslverr);
            else chk("prdata", exp_r[0], {pslverr, prdata});
            void'(exp_r.pop_front());
        end
    end

    always @(cyc_done) begin
        int ew;
        int ed;
        int cw;
        ew = exp_w.pop_front();
        ed = exp_d.pop_front();
        cw = int'(st[15:8]);
        if (ew == 99) w_cnt = (w_cnt > 0) ? 1 : 0;
        if (ew == 99) cw = (cw > 0) ? 1 : 0;
        if (ed == 99) dly = (dly > 0) ? 1 : 0;
        chk("wait states", (ew == 99) ? 1 : ew, w_cnt);
        chk("cpu waits", (ew == 99) ? 1 : ew, cw);
        chk("strobe delay", (ed == 99) ? 1 : ed, dly);
    end

    initial begin
        clk_sys_i = 1'h0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        logic [31:0] r;
        rst_n_i   = 1'h0;
        psel      = 1'h0;
        penable   = 1'h0;
        pwrite    = 1'h0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        err_total = 0;
        n_tests   = 0;
        void'($urandom(4212));
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        @(posedge clk_sys_i);
        rd_chk(`DRW_REG_CFG, {1'h0, `DRW_CFG_RESET});
        r = $urandom & 32'hE;
        apb(1'h1, `DRW_REG_CFG, r);
        rd_chk(`DRW_REG_CFG, {1'h0, r});
        apb(1'h1, 12'h00C, 32'hF);
        rd_chk(12'h00C, {1'h1, 32'h0});
        rd_chk(`DRW_REG_CFG, {1'h0, r});
        for (int i = 0; i < 16; i++) begin
            apb(1'h1, `DRW_REG_CFG, {28'h0, 3'(i >> 1), 1'h0});
            run_cyc(1'h1, i[0], i[0] ? i[3] : i[2], i[0] ? 3 : 1 + i[1]);
        end
        apb(1'h1, `DRW_REG_CFG, 32'h5);
        seen_hid = 1'h0;
        run_cyc(1'h0, 1'h0, 0, 1);
        chk("hidden refresh", 33'h1, seen_hid);
        apb(1'h1, `DRW_REG_CFG, 32'h0);
        repeat (4) @(posedge clk_sys_i);
        chk("request after hidden", 33'h0, pend);
        apb(1'h1, `DRW_REG_CFG, 32'h1);
        apb(1'h1, `DRW_REG_CFG, 32'h0);
        wait_on(0);
        wait_on(1);
        wait_on(2);
        repeat (2) @(posedge clk_sys_i);
        chk("request cleared", 33'h0, pend);
        apb(1'h1, `DRW_REG_CFG, 32'h1);
        apb(1'h1, `DRW_REG_CFG, 32'h0);
        wait_on(1);
        run_cyc(1'h1, 1'h0, 99, 99);
        repeat (4) @(posedge clk_sys_i);
        stop_test();
    end
endmodule
